/* adcl_cfg.svh */
// register offsets, field positions, reset values and timing counts
`ifndef ADCL_CFG_SVH
`define ADCL_CFG_SVH
`define ADCL_OFF_SC1      12'h000
`define ADCL_OFF_SC2      12'h004
`define ADCL_OFF_CFG      12'h008
`define ADCL_OFF_RESH     12'h00c
`define ADCL_OFF_RESL     12'h010
`define ADCL_OFF_CVH      12'h014
`define ADCL_OFF_CVL      12'h018
`define ADCL_OFF_PCTL1    12'h01c
`define ADCL_OFF_PCTL2    12'h020
`define ADCL_OFF_PWR      12'h024
`define ADCL_SC1_RST      8'h1f
`define ADCL_SC2_RST      8'h00
`define ADCL_CFG_RST      8'h00
`define ADCL_SC1_CONV_COMPLETE_FLAG     7
`define ADCL_SC1_COMPLETE_IRQ_ENABLE     6
`define ADCL_SC1_CONT     5
`define ADCL_SC2_ACT      7
`define ADCL_SC2_TRG      6
`define ADCL_SC2_CFE      5
`define ADCL_SC2_CGT      4
`define ADCL_CFG_LP       7
`define ADCL_CFG_LS       4
`define ADCL_CLK_BUS      2'b00
`define ADCL_CLK_ASYNC    2'b11
`define ADCL_RES_8        2'b00
`define ADCL_RES_12       2'b01
`define ADCL_RES_10       2'b10
`define ADCL_HALF_SHORT   7
`define ADCL_HALF_LONG    47
`define ADCL_SAR_STEPS    12
`endif

/* adcl_pkg.sv */
// types shared by the converter control block
package adcl_pkg;
  typedef struct packed {
    logic       low_power_select;
    logic [1:0] clock_divide_select;
    logic       long_sample_select;
    logic [1:0] resolution;
    logic [1:0] input_clock_select;
  } adcl_cfg_t;
  typedef struct packed {
    logic       stop3;
    logic       stop12;
  } adcl_pwr_t;
  typedef enum logic [2:0] {
    ADCL_IDLE   = 3'b001,
    ADCL_SAMPLE = 3'b010,
    ADCL_CONV   = 3'b100
  } adcl_state_t;
endpackage

/* adcl_ctrl.sv */
// converter control: registers, sequencing, low-power handling
// Behaviour
// - stop3 without async clock aborts to idle
// - result registers kept through stop3
// - after abort wait for new trigger
// - stop3 with async clock keeps converting
// - stop3 starts by hardware trigger or continuous
// - stop3 completion sets flag, wakes if enabled
// - stop1/stop2 resets all registers, disables
// - configuration register field layout
// - active flag shows conversion in progress
// - trigger, compare enable, direction bit positions
// - register two bits 3:0 read zero
// - read-only completion flag at bit 7
// - interrupt enable and continuous select bits
// - bits 4:0 select input channel
// - saturate to full scale or zero
// - sample 3.5 or 23.5 conversion clocks; the code samples for 4 or 24 clock enables
// - convert regardless of pin control bit
// - register one write aborts and restarts
// - discard result while low byte pending
`timescale 1ns/1ns
`include "adcl_cfg.svh"
module adcl_ctrl #(
  parameter int NCH = 16
) (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [11:0]             paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic                    hw_trigger,
  input  wire logic                    async_conv_clock,
  input  wire logic                    comp_in,
  output logic                         sample_en,
  output logic      [4:0]              channel_out,
  output logic      [11:0]             dac_code,
  output logic      [NCH-1:0]          pin_analog_en,
  output logic                         wake_irq
);
  import adcl_pkg::*;

  logic [7:0]  sc1_r;
  logic [7:0]  sc2_r;
  adcl_cfg_t   cfg_r;
  logic [7:0]  cvh_r;
  logic [7:0]  cvl_r;
  logic [7:0]  pctl1_r;
  logic [7:0]  pctl2_r;
  adcl_pwr_t   pwr_r;
  logic [11:0] res_r;
  logic        blk_r;
  logic        conv_complete_flag_r;
  adcl_state_t st_r;
  logic [5:0]  cnt_r;
  logic [3:0]  bit_r;
  logic [11:0] sar_r;
  logic [3:0]  dcnt_r;
  logic        ck_en;
  logic [2:0]  async_s;
  logic [2:0]  trg_s;
  logic        trg_edge;
  logic        trg_q;
  logic        wr;
  logic        rd;
  logic        soft_rst;

  assign wr = psel & penable & pwrite;
  assign rd = psel & penable & ~pwrite;
  assign pready = 1'b1;
  assign soft_rst = pwr_r.stop12;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    hit = (a[11:2] == o[11:2]);
  endfunction

  function automatic logic mapped(input logic [11:0] a);
    mapped = hit(a, `ADCL_OFF_SC1) | hit(a, `ADCL_OFF_SC2)
           | hit(a, `ADCL_OFF_CFG) | hit(a, `ADCL_OFF_RESH)
           | hit(a, `ADCL_OFF_RESL) | hit(a, `ADCL_OFF_CVH)
           | hit(a, `ADCL_OFF_CVL) | hit(a, `ADCL_OFF_PCTL1)
           | hit(a, `ADCL_OFF_PCTL2) | hit(a, `ADCL_OFF_PWR);
  endfunction

  assign pslverr = psel & penable & ~mapped(paddr);

  logic async_sel;
  logic stop_abort;
  logic sc1_wr;
  logic mode_wr;
  logic conv_done;
  logic cmp_ok;
  logic [11:0] full;
  logic [11:0] cmpv;
  logic [11:0] cmp_diff;

  assign async_sel  = cfg_r.input_clock_select == `ADCL_CLK_ASYNC;
  assign stop_abort = pwr_r.stop3 & ~async_sel;
  assign sc1_wr     = wr & hit(paddr, `ADCL_OFF_SC1);
  assign mode_wr    = wr & (hit(paddr, `ADCL_OFF_SC2)
                    | hit(paddr, `ADCL_OFF_CFG)
                    | hit(paddr, `ADCL_OFF_CVH)
                    | hit(paddr, `ADCL_OFF_CVL));

  // async clock and trigger synchroniser, trigger edge counts once stages 2 and 3 agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      async_s <= 3'h0;
      trg_s   <= 3'h0;
      trg_q   <= 1'b0;
    end else begin
      async_s <= {async_s[1:0], async_conv_clock};
      trg_s   <= {trg_s[1:0], hw_trigger};
      if (trg_s[2] == trg_s[1]) begin
        trg_q <= trg_s[2];
      end
    end
  end
  assign trg_edge = (trg_s[2] == trg_s[1]) & trg_s[2] & ~trg_q;

  logic [3:0] div_max;
  always_comb begin
    div_max = (4'h1 << cfg_r.clock_divide_select) - 4'h1;
  end

  // conversion clock enable: divided bus clock or async clock edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dcnt_r <= 4'h0;
      ck_en  <= 1'b0;
    end else if (async_sel) begin
      dcnt_r <= 4'h0;
      ck_en  <= (async_s[2] == async_s[1]) & async_s[1]
              & ~async_s[0] ? 1'b0 : (async_s[2] & ~async_s[1]) == 1'b0
              ? 1'b0 : 1'b1;
    end else if (dcnt_r >= div_max) begin
      dcnt_r <= 4'h0;
      ck_en  <= 1'b1;
    end else begin
      dcnt_r <= dcnt_r + 4'h1;
      ck_en  <= 1'b0;
    end
  end

  always_comb begin
    unique case (cfg_r.resolution)
      `ADCL_RES_12: full = 12'hfff;
      `ADCL_RES_10: full = 12'h3ff;
      default:      full = 12'h0ff;
    endcase
  end

  assign cmpv     = {cvh_r[3:0], cvl_r};
  assign cmp_diff = sar_r - cmpv;
  assign cmp_ok   = ~sc2_r[`ADCL_SC2_CFE]
                  | (sc2_r[`ADCL_SC2_CGT] ? (sar_r >= cmpv)
                                          : (sar_r < cmpv));

  function automatic logic [11:0] trial(input logic [11:0] s,
                                        input logic [3:0]  b);
    trial = (b != 4'h0) ? (s | (12'h001 << (b - 4'h1))) : s;
  endfunction

  logic start_req;
  logic sc1_off;
  logic [3:0] steps;
  logic [11:0] sar_set;
  assign steps = cfg_r.resolution == `ADCL_RES_12 ? 4'd12 :
                 cfg_r.resolution == `ADCL_RES_10 ? 4'd10 : 4'd8;
  // hardware trigger also starts in stop3 with async clock
  assign start_req = (sc2_r[`ADCL_SC2_TRG] & trg_edge)
                   | (sc1_wr & (pwdata[4:0] != 5'h1f));
  // channel code all ones switches the converter off
  assign sc1_off = sc1_wr & (pwdata[4:0] == 5'h1f);
  // decided bit merged in, next trial code loaded with it
  assign sar_set = sar_r | ({11'h0, comp_in} << (bit_r - 4'h1));
  assign conv_done = (st_r == ADCL_CONV) & ck_en & (bit_r == 4'h0);

  logic blocked;
  logic [4:0] chan_eff;
  assign chan_eff = sc1_wr ? pwdata[4:0] : sc1_r[4:0];
  // new result dropped after high byte read until low byte read (not in 8-bit)
  assign blocked = blk_r & (cfg_r.resolution != `ADCL_RES_8);

  // conversion sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r     <= ADCL_IDLE;
      cnt_r    <= 6'h0;
      bit_r    <= 4'h0;
      sar_r    <= 12'h000;
      dac_code <= 12'h000;
    end else if (soft_rst | stop_abort | mode_wr | sc1_off) begin
      st_r     <= ADCL_IDLE;
      cnt_r    <= 6'h0;
      bit_r    <= 4'h0;
      sar_r    <= 12'h000;
      dac_code <= 12'h000;
    end else if (start_req) begin
      st_r  <= ADCL_SAMPLE;
      cnt_r <= 6'h0;
      sar_r <= 12'h000;
    end else begin
      unique case (st_r)
        ADCL_IDLE: begin
          cnt_r <= 6'h0;
        end
        ADCL_SAMPLE: begin
          // half-cycle units, two per clock enable, so the sample lasts 4 or 24 clock enables
          if (ck_en) begin
            if (cnt_r >= (cfg_r.long_sample_select ? 6'(`ADCL_HALF_LONG)
                                     : 6'(`ADCL_HALF_SHORT)) - 6'd2) begin
              st_r  <= ADCL_CONV;
              bit_r <= steps;
              sar_r <= 12'h000;
              dac_code <= trial(12'h000, steps);
              cnt_r <= 6'h0;
            end else begin
              cnt_r <= cnt_r + 6'd2;
            end
          end
        end
        ADCL_CONV: begin
          if (ck_en) begin
            if (bit_r != 4'h0) begin
              sar_r <= sar_set;
              bit_r <= bit_r - 4'h1;
              dac_code <= trial(sar_set, bit_r - 4'h1);
            end else if (sc1_r[`ADCL_SC1_CONT]
                         | (blocked & ~(sc2_r[`ADCL_SC2_CFE] & ~cmp_ok))) begin
              st_r  <= ADCL_SAMPLE;
              cnt_r <= 6'h0;
            end else begin
              st_r  <= ADCL_IDLE;
            end
          end
        end
        default: st_r <= ADCL_IDLE;
      endcase
    end
  end

  // result, completion flag, read-order blocking
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_r  <= 12'h000;
      conv_complete_flag_r <= 1'b0;
      blk_r  <= 1'b0;
    end else if (soft_rst) begin
      res_r  <= 12'h000;
      conv_complete_flag_r <= 1'b0;
      blk_r  <= 1'b0;
    end else begin
      if (rd & hit(paddr, `ADCL_OFF_RESH)) begin
        blk_r <= 1'b1;
      end else if (rd & hit(paddr, `ADCL_OFF_RESL)) begin
        blk_r <= 1'b0;
      end
      // completion set wins over the clearing sc1 write
      if (conv_done & cmp_ok & ~blocked) begin
        res_r  <= sc2_r[`ADCL_SC2_CFE] ? (cmp_diff & full)
                                        : (sar_r & full);
        conv_complete_flag_r <= 1'b1;
      end else if (sc1_wr | mode_wr | (rd & hit(paddr, `ADCL_OFF_RESL))) begin
        conv_complete_flag_r <= 1'b0;
      end
    end
  end

  // control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sc1_r   <= `ADCL_SC1_RST;
      sc2_r   <= `ADCL_SC2_RST;
      cfg_r   <= adcl_cfg_t'(`ADCL_CFG_RST);
      cvh_r   <= 8'h00;
      cvl_r   <= 8'h00;
      pctl1_r <= 8'h00;
      pctl2_r <= 8'h00;
      pwr_r   <= '0;
    end else if (soft_rst) begin
      sc1_r   <= `ADCL_SC1_RST;
      sc2_r   <= `ADCL_SC2_RST;
      cfg_r   <= adcl_cfg_t'(`ADCL_CFG_RST);
      cvh_r   <= 8'h00;
      cvl_r   <= 8'h00;
      pctl1_r <= 8'h00;
      pctl2_r <= 8'h00;
      pwr_r   <= '0;
    end else if (wr) begin
      if (hit(paddr, `ADCL_OFF_SC1)) sc1_r <= {1'b0, pwdata[6:0]};
      if (hit(paddr, `ADCL_OFF_SC2)) sc2_r <= {1'b0, pwdata[6:4], 4'h0};
      if (hit(paddr, `ADCL_OFF_CFG)) cfg_r <= adcl_cfg_t'(pwdata[7:0]);
      if (hit(paddr, `ADCL_OFF_CVH)) cvh_r <= {4'h0, pwdata[3:0]};
      if (hit(paddr, `ADCL_OFF_CVL)) cvl_r <= pwdata[7:0];
      if (hit(paddr, `ADCL_OFF_PCTL1)) pctl1_r <= pwdata[7:0];
      if (hit(paddr, `ADCL_OFF_PCTL2)) pctl2_r <= pwdata[7:0];
      if (hit(paddr, `ADCL_OFF_PWR)) pwr_r <= adcl_pwr_t'(pwdata[1:0]);
    end
  end

  // read mux
  always_comb begin
    prdata = 32'h0;
    if (rd) begin
      if (hit(paddr, `ADCL_OFF_SC1)) prdata[7:0] = {conv_complete_flag_r, sc1_r[6:0]};
      if (hit(paddr, `ADCL_OFF_SC2))
        prdata[7:0] = {st_r != ADCL_IDLE, sc2_r[6:4], 4'h0};
      if (hit(paddr, `ADCL_OFF_CFG)) prdata[7:0] = cfg_r;
      if (hit(paddr, `ADCL_OFF_RESH)) prdata[7:0] = {4'h0, res_r[11:8]};
      if (hit(paddr, `ADCL_OFF_RESL)) prdata[7:0] = res_r[7:0];
      if (hit(paddr, `ADCL_OFF_CVH)) prdata[7:0] = cvh_r;
      if (hit(paddr, `ADCL_OFF_CVL)) prdata[7:0] = cvl_r;
      if (hit(paddr, `ADCL_OFF_PCTL1)) prdata[7:0] = pctl1_r;
      if (hit(paddr, `ADCL_OFF_PCTL2)) prdata[7:0] = pctl2_r;
      if (hit(paddr, `ADCL_OFF_PWR)) prdata[1:0] = pwr_r;
    end
  end

  // analog front-end controls; channel routed regardless of pin bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_en     <= 1'b0;
      channel_out   <= 5'h1f;
      pin_analog_en <= '0;
      wake_irq      <= 1'b0;
    end else begin
      sample_en     <= st_r == ADCL_SAMPLE;
      channel_out   <= chan_eff;
      pin_analog_en <= NCH'({pctl2_r, pctl1_r});
      wake_irq      <= conv_complete_flag_r & sc1_r[`ADCL_SC1_COMPLETE_IRQ_ENABLE];
    end
  end

  logic active_a_q;
  assign active_a_q = st_r != ADCL_IDLE;

  abort_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    stop_abort |=> st_r == ADCL_IDLE)
    else $error("stop3 abort did not idle");
  result_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    pwr_r.stop3 & ~conv_done & ~soft_rst |=> $stable(res_r))
    else $error("result changed in stop3");
  no_resume_a: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(pwr_r.stop3) & st_r == ADCL_IDLE & ~start_req |=> st_r == ADCL_IDLE)
    else $error("conversion resumed alone");
  keep_run_a: assert property (@(posedge pclk) disable iff (!presetn)
    pwr_r.stop3 & async_sel & st_r == ADCL_CONV & ~mode_wr & ~start_req
    & ~soft_rst & ~ck_en |=> st_r == ADCL_CONV)
    else $error("conversion stopped in stop3");
  done_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    conv_done & cmp_ok & ~blocked & ~soft_rst |=> conv_complete_flag_r ##1 wake_irq == sc1_r[6])
    else $error("completion flag missing");
  deep_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
    soft_rst |=> sc1_r == `ADCL_SC1_RST && cfg_r == '0 && !conv_complete_flag_r)
    else $error("deep stop kept state");
  active_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd & hit(paddr, `ADCL_OFF_SC2) |-> prdata[7] == active_a_q
    && prdata[3:0] == 4'h0)
    else $error("active flag wrong");
  block_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
    conv_done & blocked & ~conv_complete_flag_r & ~soft_rst |=> !conv_complete_flag_r)
    else $error("blocked result set flag");
  chan_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    sc1_off |=> st_r == ADCL_IDLE)
    else $error("channel off did not idle");
  chan_route_a: assert property (@(posedge pclk) disable iff (!presetn)
    sc1_wr |=> channel_out == $past(pwdata[4:0]))
    else $error("channel not routed");
endmodule

/* adcl_ain_model.sv */
// analog input pin model: comparator decision for the held input level
`timescale 1ns/1ns
module adcl_ain_model (
  input  wire logic [12:0] level,
  input  wire logic [11:0] dac_code,
  output logic             comp_in
);
  // 13'h1000 sits above the high reference, zero at the low one
  assign comp_in = ({1'b0, dac_code} <= level);
endmodule

/* adcl_tb.sv */
// register-level testbench for the converter control block
`timescale 1ns/1ns
`include "adcl_cfg.svh"
module testbench;
  import adcl_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        hw_trigger = 1'b0;
  logic        aclk = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [12:0] level = 13'h1000;
  logic [31:0] prdata, rd, res;
  logic        pready, pslverr, rerr, comp_in, sample_en, wake_irq;
  logic [4:0]  channel_out;
  logic [11:0] dac_code;
  logic [15:0] pin_analog_en;
  int          err_total = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  int          samp = 0;
  logic [7:0]  cfgs [4] = '{8'h90, 8'h94, 8'h08, 8'h98};
  logic [12:0] lvls [4] = '{13'h1000, 13'h1000, 13'h0000, 13'h1000};
  logic [15:0] exps [4] = '{16'h00ff, 16'h0fff, 16'h0000, 16'h03ff};

  adcl_ctrl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hw_trigger(hw_trigger), .async_conv_clock(aclk), .comp_in(comp_in),
    .sample_en(sample_en), .channel_out(channel_out), .dac_code(dac_code),
    .pin_analog_en(pin_analog_en), .wake_irq(wake_irq));
  adcl_ain_model u_ain (.level(level), .dac_code(dac_code),
    .comp_in(comp_in));

  always #10 pclk = ~pclk;
  always #36 aclk = ~aclk;

  task automatic test_done();
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc++;
    if (sample_en === 1'b1) samp++;
    if (cyc == 20000) begin
      err_total++;
      test_done();
    end
  end

  task automatic xfer(input logic [11:0] a, input logic w,
                      input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask

  task automatic rdreg(input logic [11:0] a);
    xfer(a, 1'b0, 32'h0);
  endtask

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wait_done();
    int k;
    k = 0;
    rdreg(`ADCL_OFF_SC1);
    while (rd[7] !== 1'b1 && k < 300) begin
      rdreg(`ADCL_OFF_SC1);
      k++;
    end
    // registered wake output follows the flag one edge later
    @(posedge pclk);
    chk("conv_complete_flag", 32'h1, {31'h0, rd[7]});
  endtask

  // high byte first, then low byte
  task automatic get_res();
    res = 32'h0;
    rdreg(`ADCL_OFF_RESH);
    res[15:8] = rd[7:0];
    rdreg(`ADCL_OFF_RESL);
    res[7:0] = rd[7:0];
  endtask

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rdreg(`ADCL_OFF_SC1);
    chk("sc1 reset", 32'h1f, rd);
    rdreg(`ADCL_OFF_SC2);
    chk("sc2 reset", 32'h00, rd);
    rdreg(`ADCL_OFF_CFG);
    chk("cfg reset", 32'h00, rd);
    wr(`ADCL_OFF_CFG, 32'h98);
    rdreg(`ADCL_OFF_CFG);
    chk("cfg fields", 32'h98, rd);
    wr(`ADCL_OFF_SC2, 32'h3c);
    rdreg(`ADCL_OFF_SC2);
    chk("sc2 fields", 32'h30, rd);
    wr(`ADCL_OFF_SC2, 32'h00);
    wr(`ADCL_OFF_PCTL1, 32'h02);
    repeat (2) @(posedge pclk);
    chk("pin_analog_en", 32'h2, {16'h0, pin_analog_en});
    rdreg(12'h3fc);
    chk("unmapped err", 32'h1, {31'h0, rerr});
    chk("unmapped data", 32'h0, rd);
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      wr(`ADCL_OFF_CFG, {24'h0, cfgs[i]});
      level <= lvls[i];
      samp = 0;
      wr(`ADCL_OFF_SC1, 32'h41);
      rdreg(`ADCL_OFF_SC2);
      chk("conv_active_flag", 32'h1, {31'h0, rd[7]});
      chk("channel_out", 32'h1, {27'h0, channel_out});
      wait_done();
      chk("sample length", cfgs[i][4] ? 32'd24 : 32'd4, samp);
      chk("wake_irq", 32'h1, {31'h0, wake_irq});
      get_res();
      chk("result", {16'h0, exps[i]}, res);
    end
    $display("test conversions done");
    wr(`ADCL_OFF_CFG, 32'h98);
    level <= 13'h0000;
    wr(`ADCL_OFF_SC1, 32'h01);
    wr(`ADCL_OFF_PWR, 32'h02);
    rdreg(`ADCL_OFF_SC2);
    chk("active in stop3", 32'h0, {31'h0, rd[7]});
    wr(`ADCL_OFF_PWR, 32'h00);
    repeat (100) @(posedge pclk);
    rdreg(`ADCL_OFF_SC2);
    chk("idle after stop3", 32'h0, {31'h0, rd[7]});
    get_res();
    chk("result kept", 32'h3ff, res);
    $display("test stop3 bus clock done");
    wr(`ADCL_OFF_CFG, 32'h0b);
    level <= 13'h1000;
    wr(`ADCL_OFF_SC1, 32'h41);
    wr(`ADCL_OFF_PWR, 32'h02);
    wait_done();
    chk("wake_irq", 32'h1, {31'h0, wake_irq});
    get_res();
    chk("result stop3", 32'h3ff, res);
    wr(`ADCL_OFF_SC2, 32'h40);
    @(posedge pclk);
    hw_trigger <= 1'b1;
    repeat (8) @(posedge pclk);
    hw_trigger <= 1'b0;
    wait_done();
    chk("wake_irq trig", 32'h1, {31'h0, wake_irq});
    get_res();
    chk("result trig", 32'h3ff, res);
    wr(`ADCL_OFF_PWR, 32'h00);
    $display("test stop3 async clock done");
    wr(`ADCL_OFF_PWR, 32'h01);
    rdreg(`ADCL_OFF_CFG);
    chk("cfg after stop1", 32'h00, rd);
    rdreg(`ADCL_OFF_SC1);
    chk("sc1 after stop1", 32'h1f, rd);
    rdreg(`ADCL_OFF_SC2);
    chk("sc2 after stop1", 32'h00, rd);
    chk("pins after stop1", 32'h0, {16'h0, pin_analog_en});
    $display("test stop1 done");
    wr(`ADCL_OFF_CFG, 32'h08);
    level <= 13'h1000;
    wr(`ADCL_OFF_SC1, 32'h01);
    wait_done();
    rdreg(`ADCL_OFF_RESH);
    level <= 13'h0000;
    wr(`ADCL_OFF_SC1, 32'h01);
    repeat (60) @(posedge pclk);
    rdreg(`ADCL_OFF_SC1);
    chk("blocked flag", 32'h0, {31'h0, rd[7]});
    rdreg(`ADCL_OFF_RESL);
    chk("blocked result", 32'hff, rd);
    wait_done();
    get_res();
    chk("unblocked result", 32'h0, res);
    $display("test blocking done");
    wr(`ADCL_OFF_SC2, 32'h30);
    wr(`ADCL_OFF_CVH, 32'h01);
    wr(`ADCL_OFF_CVL, 32'h00);
    level <= 13'h1000;
    wr(`ADCL_OFF_SC1, 32'h01);
    wait_done();
    get_res();
    chk("compare result", 32'h2ff, res);
    wr(`ADCL_OFF_SC2, 32'h20);
    wr(`ADCL_OFF_SC1, 32'h01);
    repeat (60) @(posedge pclk);
    rdreg(`ADCL_OFF_SC1);
    chk("compare false flag", 32'h0, {31'h0, rd[7]});
    wr(`ADCL_OFF_SC2, 32'h00);
    wr(`ADCL_OFF_SC1, 32'h21);
    repeat (60) @(posedge pclk);
    rdreg(`ADCL_OFF_SC2);
    chk("continuous active", 32'h1, {31'h0, rd[7]});
    wr(`ADCL_OFF_SC1, 32'h3f);
    rdreg(`ADCL_OFF_SC2);
    chk("channel off idle", 32'h0, {31'h0, rd[7]});
    $display("test compare and continuous done");
    test_done();
  end
endmodule
